// File: verilog/gpx_pkg.sv
// Constants, register map and state type for the 16-bit serial I/O expander.
`default_nettype none

package gpx_pkg;

  // Port geometry.
  localparam int GPX_PORT_W = 8;
  localparam int GPX_PORTS = 2;

  // Fixed upper five bits of the 7-bit bus address; the straps fill bits 1 and 0.
  localparam logic [4:0] GPX_ADDR_FIXED = 5'h1d;

  // Register groups, selected by command bits 2:1; bit 0 picks the port.
  localparam logic [1:0] GPX_GRP_IN = 2'h0;
  localparam logic [1:0] GPX_GRP_OUT = 2'h1;
  localparam logic [1:0] GPX_GRP_POL = 2'h2;
  localparam logic [1:0] GPX_GRP_CFG = 2'h3;
  localparam logic [2:0] GPX_PTR_RST = 3'h0;

  // Reset values.
  localparam logic [7:0] GPX_OUT_RST = 8'hff;
  localparam logic [7:0] GPX_POL_RST = 8'h00;
  localparam logic [7:0] GPX_CFG_RST = 8'hff;

  // Idle levels of {addr_strap_hi, addr_strap_lo, sda, scl} after reset.
  localparam logic [3:0] GPX_LINE_IDLE = 4'h3;

  // Serial byte framing: the falling edge after the eighth rising edge completes a byte.
  localparam logic [3:0] GPX_BIT_LAST = 4'h8;

  // Glitch filter: pulses up to the spike time are rejected.
  localparam int GPX_CLK_NS = 4;
  localparam int GPX_SPIKE_NS = 50;
  localparam int GPX_FILT_CYC = (GPX_SPIKE_NS + GPX_CLK_NS) / GPX_CLK_NS;

  typedef enum logic [3:0] {
    GPX_ST_IDLE,
    GPX_ST_ADDR,
    GPX_ST_ACK_ADDR,
    GPX_ST_CMD,
    GPX_ST_ACK_CMD,
    GPX_ST_WR,
    GPX_ST_ACK_WR,
    GPX_ST_RD,
    GPX_ST_MACK
  } gpx_state_t;

endpackage : gpx_pkg

`default_nettype wire

// File: verilog/gpx_expander.sv
// Serial-bus controlled 16-bit I/O expander with change alert.
`default_nettype none

module gpx_expander #(
  parameter int PORT_W = gpx_pkg::GPX_PORT_W,
  parameter int FILT_CYC = gpx_pkg::GPX_FILT_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_out,
  output logic sda_oe_out,
  input wire logic addr_strap_lo_in,
  input wire logic addr_strap_hi_in,
  input wire logic [2*PORT_W-1:0] port_in_in,
  output logic [2*PORT_W-1:0] port_out_out,
  output logic [2*PORT_W-1:0] port_oe_out,
  output logic alert_n_out,
  output logic alert_n_oe_out
);
  import gpx_pkg::*;

  localparam int NP = 2 * PORT_W;
  localparam int NS = NP + 4;
  localparam int FCW = $clog2(FILT_CYC + 1);
  localparam logic [NS-1:0] FILT_RST = {GPX_LINE_IDLE, {NP{1'b0}}};
  localparam logic [FCW-1:0] FILT_LAST = FCW'(FILT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and glitch filters.
  logic [NS-1:0] raw;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [NS-1:0] filt;
  logic [FCW-1:0] fcnt [NS];

  assign raw = {addr_strap_hi_in, addr_strap_lo_in, sda_in, scl_in, port_in_in};

  // A level must hold past the spike time before it is believed; this costs a
  // fixed latency but keeps bus ringing from forging start or stop conditions.
  for (genvar g = 0; g < NS; g++) begin : g_filt
    always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
        sync1[g] <= FILT_RST[g];
        sync2[g] <= FILT_RST[g];
        filt[g] <= FILT_RST[g];
        fcnt[g] <= '0;
      end else begin
        sync1[g] <= raw[g];
        sync2[g] <= sync1[g];
        if (sync2[g] == filt[g]) begin
          fcnt[g] <= '0;
        end else if (fcnt[g] == FILT_LAST) begin
          filt[g] <= sync2[g];
          fcnt[g] <= '0;
        end else begin
          fcnt[g] <= fcnt[g] + 1'b1;
        end
      end
    end
  end

  logic [NP-1:0] pins;
  logic scl_f;
  logic sda_f;
  logic [1:0] strap;
  assign pins = filt[NP-1:0];
  assign scl_f = filt[NP];
  assign sda_f = filt[NP+1];
  assign strap = filt[NP+3:NP+2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection.
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_ev = scl_f & scl_d & ~sda_d & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Serial state machine.
  gpx_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic rw;
  logic sel;
  logic [2:0] ptr;
  logic [2:0] cur;
  logic [7:0] rd_data;
  logic addr_hit;
  logic byte_done;

  assign cur = {ptr[2:1], sel};
  assign byte_done = scl_fall && (bitcnt == GPX_BIT_LAST);
  assign addr_hit = (shreg[7:1] == {GPX_ADDR_FIXED, strap});

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= GPX_ST_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      tx <= '0;
      rw <= 1'b0;
      sel <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_ev) begin
      state <= GPX_ST_ADDR;
      bitcnt <= '0;
      sda_oe_out <= 1'b0;
      sel <= ptr[0];
    end else if (stop_ev) begin
      state <= GPX_ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      if (scl_rise) begin
        shreg <= {shreg[6:0], sda_f};
        bitcnt <= bitcnt + 1'b1;
      end
      if (scl_fall) begin
        case (state)
          GPX_ST_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          GPX_ST_ADDR: begin
            if (byte_done) begin
              if (addr_hit) begin
                state <= GPX_ST_ACK_ADDR;
                rw <= shreg[0];
                sda_oe_out <= 1'b1;
              end else begin
                state <= GPX_ST_IDLE;
              end
            end
          end
          GPX_ST_ACK_ADDR: begin
            bitcnt <= '0;
            if (rw) begin
              state <= GPX_ST_RD;
              tx <= rd_data;
              sda_oe_out <= ~rd_data[7];
            end else begin
              state <= GPX_ST_CMD;
              sda_oe_out <= 1'b0;
            end
          end
          GPX_ST_CMD: begin
            if (byte_done) begin
              state <= GPX_ST_ACK_CMD;
              sel <= shreg[0];
              sda_oe_out <= 1'b1;
            end
          end
          GPX_ST_ACK_CMD, GPX_ST_ACK_WR: begin
            state <= GPX_ST_WR;
            bitcnt <= '0;
            sda_oe_out <= 1'b0;
            if (state == GPX_ST_ACK_WR) begin
              sel <= ~sel;
            end
          end
          GPX_ST_WR: begin
            if (byte_done) begin
              state <= GPX_ST_ACK_WR;
              sda_oe_out <= 1'b1;
            end
          end
          GPX_ST_RD: begin
            if (byte_done) begin
              state <= GPX_ST_MACK;
              sda_oe_out <= 1'b0;
              sel <= ~sel;
            end else begin
              tx <= {tx[6:0], 1'b0};
              sda_oe_out <= ~tx[6];
            end
          end
          GPX_ST_MACK: begin
            if (!shreg[0]) begin
              state <= GPX_ST_RD;
              bitcnt <= '0;
              tx <= rd_data;
              sda_oe_out <= ~rd_data[7];
            end else begin
              state <= GPX_ST_IDLE;
            end
          end
          default: begin
            state <= GPX_ST_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: the line is only ever pulled low.
  assign sda_out_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and register file.
  logic cmd_ev;
  logic wr_ev;
  logic [7:0] outp [GPX_PORTS];
  logic [7:0] pol [GPX_PORTS];
  logic [7:0] cfg [GPX_PORTS];
  logic [7:0] in_latch [GPX_PORTS];

  assign cmd_ev = byte_done && (state == GPX_ST_CMD) && !start_ev && !stop_ev;
  assign wr_ev = byte_done && (state == GPX_ST_WR) && !start_ev && !stop_ev;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ptr <= GPX_PTR_RST;
    end else if (cmd_ev) begin
      ptr <= shreg[2:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int p = 0; p < GPX_PORTS; p++) begin
        outp[p] <= GPX_OUT_RST;
        pol[p] <= GPX_POL_RST;
        cfg[p] <= GPX_CFG_RST;
      end
    end else if (wr_ev) begin
      case (cur[2:1])
        GPX_GRP_OUT: outp[cur[0]] <= shreg;
        GPX_GRP_POL: pol[cur[0]] <= shreg;
        GPX_GRP_CFG: cfg[cur[0]] <= shreg;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (cur[2:1])
      GPX_GRP_IN: rd_data = in_latch[cur[0]] ^ pol[cur[0]];
      GPX_GRP_OUT: rd_data = outp[cur[0]];
      GPX_GRP_POL: rd_data = pol[cur[0]];
      GPX_GRP_CFG: rd_data = cfg[cur[0]];
      default: rd_data = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture and change alert.
  logic primed;
  logic cap_ev;
  logic [NP-1:0] alert_vec;
  logic [NP-1:0] latch_flat;
  logic [NP-1:0] cfg_flat;
  logic [NP-1:0] out_flat;

  // The snapshot is taken on the acknowledge rising edge, so a change during
  // that clock can be swallowed; the compare afterwards catches the rest.
  assign cap_ev = scl_rise && (cur[2:1] == GPX_GRP_IN) && !start_ev && !stop_ev
    && (((state == GPX_ST_ACK_ADDR) && rw) || ((state == GPX_ST_MACK) && !sda_f));

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      primed <= 1'b0;
      for (int p = 0; p < GPX_PORTS; p++) begin
        in_latch[p] <= '0;
      end
    end else if (!primed) begin
      primed <= 1'b1;
      for (int p = 0; p < GPX_PORTS; p++) begin
        in_latch[p] <= pins[p*PORT_W +: PORT_W];
      end
    end else if (cap_ev) begin
      in_latch[cur[0]] <= pins[cur[0]*PORT_W +: PORT_W];
    end
  end

  for (genvar p = 0; p < GPX_PORTS; p++) begin : g_flat
    assign latch_flat[p*PORT_W +: PORT_W] = in_latch[p];
    assign cfg_flat[p*PORT_W +: PORT_W] = cfg[p];
    assign out_flat[p*PORT_W +: PORT_W] = outp[p];
  end

  // Outputs are masked off; a pin turned to input may still mismatch at once.
  assign alert_vec = (pins ^ latch_flat) & cfg_flat;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      alert_n_oe_out <= 1'b0;
    end else begin
      alert_n_oe_out <= primed && (|alert_vec);
    end
  end

  assign alert_n_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.
  logic [NP-1:0] high_side_driver;
  logic [NP-1:0] low_side_driver;

  assign high_side_driver = ~cfg_flat & out_flat;
  assign low_side_driver = ~cfg_flat & ~out_flat;
  assign port_out_out = high_side_driver;
  assign port_oe_out = high_side_driver | low_side_driver;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  reset_defaults_a: assert property (@(posedge clk_in)
    !resetn_in |=> (state == GPX_ST_IDLE) && !sda_oe_out && (port_oe_out == '0)
      && (ptr == GPX_PTR_RST))
    else $error("reset did not restore defaults");

  driver_exclusive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ((high_side_driver & low_side_driver) == '0)
      && ((port_oe_out & cfg_flat) == '0))
    else $error("pin driven while input or both drivers on");

  output_no_alert_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    primed && (((pins ^ latch_flat) & cfg_flat) == '0) |=> !alert_n_oe_out)
    else $error("output pins raised the alert");

  addr_ack_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (byte_done && state == GPX_ST_ADDR && addr_hit && !start_ev && !stop_ev)
      |=> sda_oe_out && (state == GPX_ST_ACK_ADDR))
    else $error("matching address not acknowledged");

  addr_miss_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (byte_done && state == GPX_ST_ADDR && !addr_hit && !start_ev && !stop_ev)
      |=> !sda_oe_out && (state == GPX_ST_IDLE))
    else $error("foreign address answered");

  stop_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    stop_ev && !start_ev |=> (state == GPX_ST_IDLE) && !sda_oe_out)
    else $error("stop did not return to idle");

  ptr_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !cmd_ev |=> $stable(ptr))
    else $error("pointer changed without a command byte");

  out_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_ev && (cur[2:1] == GPX_GRP_OUT) |=> (outp[$past(sel)] == $past(shreg)))
    else $error("output register write lost");

  in_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_ev && (cur[2:1] == GPX_GRP_IN) |=> $stable(out_flat) && $stable(cfg_flat))
    else $error("input register write had an effect");

  port_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    primed && cap_ev && !sel |=> (in_latch[0] == $past(pins[PORT_W-1:0]))
      && $stable(in_latch[1]))
    else $error("port read cleared the wrong port");

  alert_follow_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    primed && (|alert_vec) |=> alert_n_oe_out)
    else $error("mismatch did not raise alert");

endmodule // gpx_expander

`default_nettype wire

// File: verif/gpx_i2c_master.sv
// Serial bus master model that clocks the expander and reports every byte.
`default_nettype none
module gpx_i2c_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out,
  output logic res_valid_out,
  output logic [8:0] res_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
    res_valid_out = 1'b0;
    res_out = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // The clock only toggles inside frames; between frames both lines rest high.
  task automatic start();
    wt(16);
    sda_pull_out <= 1'b1;
    wt(8);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    wt(4);
    sda_pull_out <= 1'b1;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    sda_pull_out <= 1'b0;
  endtask
  // Data moves a quarter period after the fall, so it never races the clock.
  task automatic xbit(input logic b, output logic r);
    wt(4);
    sda_pull_out <= ~b;
    wt(4);
    scl_out <= 1'b1;
    wt(4);
    #1 r = sda_in;
    wt(4);
    scl_out <= 1'b0;
  endtask
  // Nine bits are sampled off the line, so the master reads back its own bits.
  task automatic xbyte(input logic [7:0] d, input logic a);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, a};
    for (int i = 8; i >= 0; i--) begin
      xbit(s[i], r[i]);
    end
    res_out <= r;
    res_valid_out <= 1'b1;
    wt(1);
    res_valid_out <= 1'b0;
  endtask
endmodule // gpx_i2c_master
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the serial I/O expander.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpx_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [15:0] ext = 16'h0000;
  logic [15:0] out_m, pol_m, cfg_m, p_out, p_oe;
  logic scl, pull, rv, sda_oe, sda_o, al_o, al_oe;
  logic [8:0] res;
  logic [8:0] expq[$];
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  // Pins resolve from the expander's drivers; undriven pins take the outside level.
  wire logic [15:0] pins = (p_oe & p_out) | (~p_oe & ext);
  wire logic sda = ~(pull | (sda_oe & ~sda_o));
  always #2 clk_in = ~clk_in;
  gpx_expander #(.FILT_CYC(2)) gpx_expander_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .scl_in(scl), .sda_in(sda), .sda_out_out(sda_o), .sda_oe_out(sda_oe),
    .addr_strap_lo_in(strap[0]), .addr_strap_hi_in(strap[1]), .port_in_in(pins),
    .port_out_out(p_out), .port_oe_out(p_oe), .alert_n_out(al_o), .alert_n_oe_out(al_oe));
  gpx_i2c_master gpx_i2c_master_inst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_pull_out(pull), .res_valid_out(rv), .res_out(res));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {GPX_ADDR_FIXED, strap, rw};
  endfunction
  function automatic logic [7:0] ev(input logic [2:0] c);
    logic [15:0] v;
    case (c[2:1])
      GPX_GRP_IN: v = ((~cfg_m & out_m) | (cfg_m & ext)) ^ pol_m;
      GPX_GRP_OUT: v = out_m;
      GPX_GRP_POL: v = pol_m;
      default: v = cfg_m;
    endcase
    return v[8*c[0] +: 8];
  endfunction
  task automatic sb(input logic [7:0] b, input logic ma, input logic [7:0] e, input logic ea);
    expq.push_back({e, ea});
    gpx_i2c_master_inst.xbyte(b, ma);
  endtask
  task automatic wr(input logic [7:0] c, input int n, input logic [7:0] d);
    gpx_i2c_master_inst.start();
    sb(adr(0), 1, adr(0), 0);
    sb(c, 1, c, 0);
    if (n > 0) sb(d, 1, d, 0);
    gpx_i2c_master_inst.stop();
  endtask
  task automatic rd(input int n, input logic [15:0] e);
    gpx_i2c_master_inst.start();
    sb(adr(1), 1, adr(1), 0);
    for (int i = 0; i < n; i++) sb(8'hff, i == n - 1, e[8*i +: 8], i == n - 1);
    gpx_i2c_master_inst.stop();
  endtask
  task automatic rp(input logic [2:0] c);
    wr({5'h00, c}, 0, 8'h00);
    rd(2, {ev(c ^ 3'h1), ev(c)});
  endtask
  task automatic wm(input logic [2:0] c, input logic [7:0] d);
    wr({5'h00, c}, 1, d);
    case (c[2:1])
      GPX_GRP_OUT: out_m[8*c[0] +: 8] = d;
      GPX_GRP_POL: pol_m[8*c[0] +: 8] = d;
      GPX_GRP_CFG: cfg_m[8*c[0] +: 8] = d;
      default: ;
    endcase
  endtask
  task automatic flip(input int b);
    ext[b] <= ~ext[b];
    wt(20);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t pin mismatch got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [8:0] g);
    checks_done++;
    if (expq.size() == 0 || g !== expq[0]) begin
      err_total++;
      $display("[FAIL] %0t bus byte got %h", $time, g);
    end
    if (expq.size() > 0) void'(expq.pop_front());
  endtask
  task automatic chk_ports(input logic a);
    chk(p_oe, ~cfg_m);
    chk(p_out, out_m & ~cfg_m);
    chk({15'h0000, al_oe ? al_o : 1'b1}, {15'h0000, ~a});
  endtask
  task automatic do_reset();
    resetn_in <= 1'b0;
    wt(6);
    resetn_in <= 1'b1;
    out_m = {2{GPX_OUT_RST}};
    pol_m = {2{GPX_POL_RST}};
    cfg_m = {2{GPX_CFG_RST}};
    wt(24);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Results are matched in arrival order, so a lost byte shifts every later one.
  always @(posedge clk_in) begin
    if (rv) begin
      chk_byte(res);
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'he6ad_f07f));
    strap <= 2'($urandom);
    do_reset();
    chk_ports(1'b0);
    for (int c = 0; c < 8; c++) begin
      wr(8'(c), 0, 8'h00);
      rd(1, {8'h00, ev(3'(c))});
    end
    ext <= 16'($urandom);
    wt(20);
    rp(3'h0);
    chk_ports(1'b0);
    for (int c = 0; c < 8; c++) wm(3'(c), c > 5 ? (8'($urandom) | 8'h01) & 8'hfd : 8'($urandom));
    rp(3'h0);
    chk_ports(1'b0);
    for (int c = 0; c < 8; c += 2) rp(3'(c));
    flip(8);
    chk_ports(1'b1);
    wr(8'h00, 0, 8'h00);
    rd(1, {8'h00, ev(3'h0)});
    chk_ports(1'b1);
    flip(8);
    chk_ports(1'b0);
    flip(8);
    chk_ports(1'b1);
    wr(8'h01, 0, 8'h00);
    rd(1, {8'h00, ev(3'h1)});
    chk_ports(1'b0);
    wm(3'h2, out_m[7:0] ^ 8'h02);
    wt(20);
    chk_ports(1'b0);
    flip(0);
    gpx_i2c_master_inst.start();
    sb({GPX_ADDR_FIXED, ~strap, 1'b0}, 1, {GPX_ADDR_FIXED, ~strap, 1'b0}, 1);
    gpx_i2c_master_inst.stop();
    chk_ports(1'b1);
    rp(3'h0);
    chk_ports(1'b0);
    do_reset();
    chk(p_oe, 16'h0000);
    rp(3'h6);
    rp(3'h2);
    rp(3'h0);
    chk_ports(1'b0);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
